//--- shared/agd_pkg.sv
// constants shared by the converter-group post-processing block
package agd_pkg;
	// --------------------------------------------------------------
	// register indices (byte address is four times the index)
	// --------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL_GLOBAL = 6'h03;
	localparam logic [5:0] IDX_CTRL_PATTERN = 6'h04;
	localparam logic [5:0] IDX_GAIN_OFFSET = 6'h2C;
	localparam logic [5:0] IDX_PATTERN_HPF = 6'h2D;
	localparam logic [5:0] IDX_STATUS = 6'h3F;
	localparam int ADDR_W = 8;
	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int GAIN_EN_BIT = 12;
	localparam int OFFSET_EN_BIT = 8;
	localparam int PAT_SEL_BIT = 8;
	localparam int GAIN_MSB = 15;
	localparam int GAIN_LSB = 11;
	localparam int OFFSET_MSB = 9;
	localparam int RAND_MSB = 15;
	localparam int RAND_LSB = 12;
	localparam int CODE9_MSB = 11;
	localparam int CODE9_LSB = 9;
	localparam int CODE10_MSB = 8;
	localparam int CODE10_LSB = 6;
	localparam int ROUND_BIT = 5;
	localparam int CORNER_MSB = 4;
	localparam int CORNER_LSB = 1;
	localparam int HPF_EN_BIT = 0;
	// --------------------------------------------------------------
	// reset values, widths and bus answers
	// --------------------------------------------------------------
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int SAMPLE_W = 14;
	localparam int HPF_FRAC = 4;
	localparam int GAIN_FRAC = 14;
	localparam int FIFO_DEPTH = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// gain of N x 0.2 dB as a factor with 14 fraction bits
	localparam logic [15:0] GAIN_TABLE [32] = '{
		16'h4000, 16'h417C, 16'h4302, 16'h4491, 16'h4629, 16'h47CB, 16'h4977, 16'h4B2D,
		16'h4CED, 16'h4EB8, 16'h508D, 16'h526D, 16'h5459, 16'h564F, 16'h5852, 16'h5A61,
		16'h5C7B, 16'h5EA3, 16'h60D7, 16'h6319, 16'h6568, 16'h67C4, 16'h6A2F, 16'h6CA8,
		16'h6F30, 16'h71C7, 16'h746E, 16'h7724, 16'h79EA, 16'h7CC1, 16'h7FA9, 16'h82A2
	};
endpackage

//--- design/agd_fifo.sv
// small synchronous fifo with a registered read port
`timescale 1ns/1ns
module agd_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// fill level, output register not counted
	output logic [$clog2(DEPTH):0] count_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic ov_reg, ov_next;
	logic [WIDTH-1:0] od_reg, od_next;
	logic push, pop;

	// --------------------------------------------------------------
	// pointers and output register
	// --------------------------------------------------------------
	// honest full: ready drops once every slot holds a word
	assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
	assign push = in_valid_i && in_ready_o;
	assign pop = (cnt_reg != '0) && (!ov_reg || out_ready_i);
	assign out_valid_o = ov_reg;
	assign out_data_o = od_reg;
	assign count_o = cnt_reg;

	always_comb begin
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		ov_next = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_reg);
		od_next = pop ? mem_reg[rd_reg] : od_reg;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			ov_reg <= 1'b0;
			od_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			ov_reg <= ov_next;
			od_reg <= od_next;
		end
	end

	// storage needs no reset; a word is only read after it was written
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data_i;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	full_refuses_a: assert property ((cnt_reg == (AW+1)'(DEPTH)) |-> !in_ready_o)
		else $error("fifo accepts while full");
	hold_out_a: assert property ((ov_reg && !out_ready_i) |=> (ov_reg && $stable(od_reg)))
		else $error("fifo output changed while stalled");
endmodule

//--- design/agd_post_proc.sv
// post-processing path and register bank for converters 9 to 12
//
// Notes on behaviour
// - Five-bit gain code N gives gain of N times 0.2 dB on sample.
// - Gain code acts only while the global gain enable bit is one.
// - While global offset enable is one, subtract offset field from sample.
// - Offset is signed ten-bit, one step equals one 14-bit sample step.
// - With per-output select on, bits 15..12 enable random patterns outputs 9..12.
// - With per-output select on, codes 11..9 and 8..6 drive outputs 9, 10.
// - Rounding bit zero: filter output truncated to the sample width.
// - Rounding bit one: filter output rounded to the sample width.
// - Corner field k sets filter response; software writes only 2 to 10.
// - Filter enable zero bypasses the high-pass filter, one applies it.
`timescale 1ns/1ns
module agd_post_proc
	import agd_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// even samples of converter 12 in
	input wire logic [SAMPLE_W-1:0] sample_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	// corrected and filtered samples out
	output logic [SAMPLE_W-1:0] result_o,
	output logic result_valid_o,
	input wire logic result_ready_i,
	// pattern selection toward the serial outputs
	output logic [3:0] random_pattern_enable_o,
	output logic [2:0] test_pattern_code_out9_o,
	output logic [2:0] test_pattern_code_out10_o
);
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	// register selection from a byte address; 0 means unmapped
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [5:0] idx;
		idx = a[ADDR_W-1:2];
		unique case (idx)
			IDX_CTRL_GLOBAL: reg_sel = 3'h1;
			IDX_CTRL_PATTERN: reg_sel = 3'h2;
			IDX_GAIN_OFFSET: reg_sel = 3'h3;
			IDX_PATTERN_HPF: reg_sel = 3'h4;
			IDX_STATUS: reg_sel = 3'h5;
			default: reg_sel = 3'h0;
		endcase
	endfunction

	// clamp a wide signed value into the sample range
	function automatic logic [SAMPLE_W-1:0] sat14(input logic signed [31:0] v);
		if (v > 32'sd8191) begin
			sat14 = 14'h1FFF;
		end else if (v < -32'sd8192) begin
			sat14 = 14'h2000;
		end else begin
			sat14 = v[SAMPLE_W-1:0];
		end
	endfunction

	// --------------------------------------------------------------
	// register bus
	// --------------------------------------------------------------
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic gain_en_reg, gain_en_next, offset_en_reg, offset_en_next;
	logic pat_sel_reg, pat_sel_next;
	logic [15:0] gain_off_reg, gain_off_next, pat_hpf_reg, pat_hpf_next;
	logic [15:0] wmask;
	logic do_write;
	logic [$clog2(DEPTH):0] fifo_count;
	logic fifo_in_ready;

	assign s_axi_awready_o = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready_o = !w_hold_reg && !bvalid_reg;
	assign s_axi_arready_o = !rvalid_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign s_axi_rdata_o = rdata_reg;
	// the write lands one cycle after both halves are held
	assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

	// next values of the bus handshake and of every register
	always_comb begin
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg && !s_axi_bready_i;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg && !s_axi_rready_i;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		gain_en_next = gain_en_reg;
		offset_en_next = offset_en_reg;
		pat_sel_next = pat_sel_reg;
		gain_off_next = gain_off_reg;
		pat_hpf_next = pat_hpf_reg;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_hold_next = 1'b1;
			awaddr_next = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_hold_next = 1'b1;
			wdata_next = s_axi_wdata_i;
			wstrb_next = s_axi_wstrb_i;
		end
		if (do_write) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			unique case (reg_sel(awaddr_reg))
				3'h1: begin
					if (wstrb_reg[1]) begin
						gain_en_next = wdata_reg[GAIN_EN_BIT];
						offset_en_next = wdata_reg[OFFSET_EN_BIT];
					end
				end
				3'h2: begin
					if (wstrb_reg[1]) begin
						pat_sel_next = wdata_reg[PAT_SEL_BIT];
					end
				end
				// bit 10 is stored as written and read back, but no sample or pattern logic uses it
				3'h3: gain_off_next = (gain_off_reg & ~wmask) | (wdata_reg[15:0] & wmask);
				3'h4: pat_hpf_next = (pat_hpf_reg & ~wmask) | (wdata_reg[15:0] & wmask);
				3'h5: bresp_next = RESP_OKAY; // status is read only, write ignored
				default: bresp_next = RESP_SLVERR;
			endcase
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			rdata_next = 32'h0000_0000;
			unique case (reg_sel(s_axi_araddr_i))
				3'h1: begin
					rdata_next[GAIN_EN_BIT] = gain_en_reg;
					rdata_next[OFFSET_EN_BIT] = offset_en_reg;
				end
				3'h2: rdata_next[PAT_SEL_BIT] = pat_sel_reg;
				3'h3: rdata_next[15:0] = gain_off_reg;
				3'h4: rdata_next[15:0] = pat_hpf_reg;
				3'h5: rdata_next = {24'h00_0000, 3'h0, fifo_count};
				default: rresp_next = RESP_SLVERR;
			endcase
		end
	end

	// every field comes up zero so nothing is active after reset
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			gain_en_reg <= 1'b0;
			offset_en_reg <= 1'b0;
			pat_sel_reg <= 1'b0;
			gain_off_reg <= REG_RESET;
			pat_hpf_reg <= REG_RESET;
		end else begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			gain_en_reg <= gain_en_next;
			offset_en_reg <= offset_en_next;
			pat_sel_reg <= pat_sel_next;
			gain_off_reg <= gain_off_next;
			pat_hpf_reg <= pat_hpf_next;
		end
	end

	// --------------------------------------------------------------
	// sample path: offset, gain, high-pass filter
	// --------------------------------------------------------------
	logic v1_reg, v1_next, v2_reg, v2_next, v3_reg, v3_next;
	logic [SAMPLE_W-1:0] d1_reg, d1_next, d2_reg, d2_next, d3_reg, d3_next;
	logic signed [21:0] y_reg, y_next, xp_reg, xp_next;
	logic signed [21:0] xs, y_calc;
	logic signed [22:0] y_round;
	logic [SAMPLE_W-1:0] trunc_val, round_val;
	logic [3:0] corner_k;
	logic hpf_en, adv;

	// whole pipeline stalls together while stage 3 holds a word the fifo cannot take
	assign adv = !v3_reg || fifo_in_ready;
	assign sample_ready_o = adv;
	assign hpf_en = pat_hpf_reg[HPF_EN_BIT];
	assign corner_k = pat_hpf_reg[CORNER_MSB:CORNER_LSB];
	assign xs = 22'(signed'(d2_reg)) <<< HPF_FRAC;
	// y = x - x_prev + y_prev - y_prev/2^k
	assign y_calc = xs - xp_reg + y_reg - (y_reg >>> corner_k);
	assign y_round = 23'(y_calc) + 23'sd8;
	assign trunc_val = sat14(32'(y_calc >>> HPF_FRAC));
	assign round_val = sat14(32'(y_round >>> HPF_FRAC));

	always_comb begin
		v1_next = v1_reg;
		v2_next = v2_reg;
		v3_next = v3_reg;
		d1_next = d1_reg;
		d2_next = d2_reg;
		d3_next = d3_reg;
		y_next = y_reg;
		xp_next = xp_reg;
		if (adv) begin
			v1_next = sample_valid_i;
			v2_next = v1_reg;
			v3_next = v2_reg;
			if (sample_valid_i) begin
				// offset is two's complement in 14-bit steps
				d1_next = offset_en_reg ? sat14(32'(signed'(sample_i))
					- 32'(signed'(gain_off_reg[OFFSET_MSB:0]))) : sample_i;
			end
			if (v1_reg) begin
				d2_next = gain_en_reg ? sat14(32'((33'(signed'(d1_reg))
					* signed'(33'(GAIN_TABLE[gain_off_reg[GAIN_MSB:GAIN_LSB]]))) >>> GAIN_FRAC))
					: d1_reg;
			end
			if (v2_reg) begin
				if (hpf_en) begin
					y_next = y_calc;
					xp_next = xs;
					d3_next = pat_hpf_reg[ROUND_BIT] ? round_val : trunc_val;
				end else begin
					// bypass: filter history is cleared so a later enable starts clean
					y_next = '0;
					xp_next = '0;
					d3_next = d2_reg;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			v1_reg <= 1'b0;
			v2_reg <= 1'b0;
			v3_reg <= 1'b0;
			d1_reg <= '0;
			d2_reg <= '0;
			d3_reg <= '0;
			y_reg <= '0;
			xp_reg <= '0;
		end else begin
			v1_reg <= v1_next;
			v2_reg <= v2_next;
			v3_reg <= v3_next;
			d1_reg <= d1_next;
			d2_reg <= d2_next;
			d3_reg <= d3_next;
			y_reg <= y_next;
			xp_reg <= xp_next;
		end
	end

	agd_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(v3_reg),
		.in_ready_o(fifo_in_ready),
		.in_data_i(d3_reg),
		.out_valid_o(result_valid_o),
		.out_ready_i(result_ready_i),
		.out_data_o(result_o),
		.count_o(fifo_count)
	);

	// --------------------------------------------------------------
	// pattern selection
	// --------------------------------------------------------------
	logic [3:0] rand_reg, rand_next;
	logic [2:0] code9_reg, code9_next, code10_reg, code10_next;

	// per-output fields matter only while the select bit is set
	always_comb begin
		rand_next = pat_sel_reg ? pat_hpf_reg[RAND_LSB +: 4] : 4'h0;
		code9_next = pat_sel_reg ? pat_hpf_reg[CODE9_MSB:CODE9_LSB] : 3'h0;
		code10_next = pat_sel_reg ? pat_hpf_reg[CODE10_MSB:CODE10_LSB] : 3'h0;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rand_reg <= 4'h0;
			code9_reg <= 3'h0;
			code10_reg <= 3'h0;
		end else begin
			rand_reg <= rand_next;
			code9_reg <= code9_next;
			code10_reg <= code10_next;
		end
	end

	// bit 15 drives output 9, bit 12 output 12
	assign random_pattern_enable_o = {rand_reg[0], rand_reg[1], rand_reg[2], rand_reg[3]};
	assign test_pattern_code_out9_o = code9_reg;
	assign test_pattern_code_out10_o = code10_reg;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence both_halves_s;
		aw_hold_reg && w_hold_reg && !bvalid_reg;
	endsequence
	sequence resp_up_s;
		s_axi_bvalid_o;
	endsequence

	write_resp_a: assert property (both_halves_s |=> resp_up_s)
		else $error("write response missing");
	reset_zero_a: assert property ($rose(rst_n_i) |-> (gain_off_reg == 16'h0000
		&& pat_hpf_reg == 16'h0000 && !gain_en_reg && !pat_sel_reg))
		else $error("register not zero after reset");
	offset_off_a: assert property ((adv && sample_valid_i && !offset_en_reg)
		|=> d1_reg == $past(sample_i))
		else $error("offset applied while disabled");
	offset_neg_a: assert property ((adv && sample_valid_i && offset_en_reg
		&& gain_off_reg[OFFSET_MSB:0] == 10'h3FF && sample_i == 14'h0000)
		|=> d1_reg == 14'h0001)
		else $error("signed offset wrong");
	gain_bypass_a: assert property ((adv && v1_reg && !gain_en_reg)
		|=> d2_reg == $past(d1_reg))
		else $error("gain applied while disabled");
	gain_unity_a: assert property ((adv && v1_reg && gain_en_reg
		&& gain_off_reg[GAIN_MSB:GAIN_LSB] == 5'h00) |=> d2_reg == $past(d1_reg))
		else $error("zero gain code not unity");
	hpf_bypass_a: assert property ((adv && v2_reg && !hpf_en)
		|=> (d3_reg == $past(d2_reg) && y_reg == '0))
		else $error("filter not bypassed");
	trunc_mode_a: assert property ((adv && v2_reg && hpf_en && !pat_hpf_reg[ROUND_BIT])
		|=> d3_reg == $past(trunc_val))
		else $error("truncation not applied");
	round_mode_a: assert property ((adv && v2_reg && hpf_en && pat_hpf_reg[ROUND_BIT])
		|=> d3_reg == $past(round_val))
		else $error("rounding not applied");
	pattern_gate_a: assert property (!pat_sel_reg |=> ##1 (random_pattern_enable_o == 4'h0
		|| $past(pat_sel_reg)))
		else $error("pattern enabled without select");
	pattern_code_a: assert property ((pat_sel_reg && $stable(pat_hpf_reg))
		|=> test_pattern_code_out9_o == $past(pat_hpf_reg[CODE9_MSB:CODE9_LSB]))
		else $error("pattern code not passed");
endmodule

//--- dv/agd_host_bfm.sv
// host-side register bus master model for the post-processing block
`timescale 1ns/1ns
module agd_host_bfm (
	// clock
	input wire logic clk_i,
	// write channels
	output logic [7:0] awaddr_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output logic [31:0] wdata_o,
	output logic [3:0] wstrb_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic [1:0] bresp_i,
	input wire logic bvalid_i,
	output logic bready_o,
	// read channels
	output logic [7:0] araddr_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0] rresp_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	initial begin
		awaddr_o = 8'h00;
		awvalid_o = 1'b0;
		wdata_o = 32'h0;
		wstrb_o = 4'h0;
		wvalid_o = 1'b0;
		bready_o = 1'b0;
		araddr_o = 8'h00;
		arvalid_o = 1'b0;
		rready_o = 1'b0;
	end
	// one write; each half is dropped at its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
		output bit ok);
		ok = 0;
		@(posedge clk_i);
		awaddr_o <= a;
		awvalid_o <= 1'b1;
		wdata_o <= d;
		wstrb_o <= 4'h3;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		for (int n = 0; n < 100 && !ok; n++) begin
			@(posedge clk_i);
			if (awvalid_o && awready_i) awvalid_o <= 1'b0;
			if (wvalid_o && wready_i) wvalid_o <= 1'b0;
			if (bvalid_i && !awvalid_o && !wvalid_o) begin
				r = bresp_i;
				bready_o <= 1'b0;
				ok = 1;
			end
		end
	endtask
	// one read; data taken at the rvalid edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
		output bit ok);
		ok = 0;
		@(posedge clk_i);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		for (int n = 0; n < 100 && !ok; n++) begin
			@(posedge clk_i);
			if (arvalid_o && arready_i) arvalid_o <= 1'b0;
			if (rvalid_i && !arvalid_o) begin
				d = rdata_i;
				r = rresp_i;
				rready_o <= 1'b0;
				ok = 1;
			end
		end
	endtask
endmodule

//--- dv/test_agd_post_proc.sv
// self-checking testbench for the converter-group post-processing block
`timescale 1ns/1ns
module test_agd_post_proc;
	import agd_pkg::*;
	logic clk_i, rst_n_i, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, sample_valid_i, sample_ready_o;
	logic result_valid_o, result_ready_i;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, rand_o;
	logic [1:0] bresp, rresp;
	logic [13:0] sample_i, result_o;
	logic [2:0] code9_o, code10_o;
	int n_fail = 0;
	int check_count = 0;
	agd_host_bfm i_agd_host_bfm (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
		.awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
		.wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
		.araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
		.rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
	agd_post_proc #(.DEPTH(16)) i_agd_post_proc (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sample_i(sample_i),
		.sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
		.result_o(result_o), .result_valid_o(result_valid_o),
		.result_ready_i(result_ready_i), .random_pattern_enable_o(rand_o),
		.test_pattern_code_out9_o(code9_o), .test_pattern_code_out10_o(code10_o));
	// --------------------------------------------------------------
	// clock, compare and closing tasks
	// --------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic hang(input string what);
		n_fail++;
		$display("unexpected at %0t: no answer on %s", $time, what);
		end_of_test();
	endtask
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: word %h, want %h", $time, got, exp);
		end
	endtask
	task automatic cmp_sample(input logic [13:0] got, input logic [13:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: sample %h, want %h", $time, got, exp);
		end
	endtask
	// --------------------------------------------------------------
	// bus and stream helpers
	// --------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit ok;
		i_agd_host_bfm.wr(a, d, r, ok);
		if (!ok) hang("write");
		cmp_word({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		bit ok;
		i_agd_host_bfm.rd(a, d, r, ok);
		if (!ok) hang("read");
		cmp_word({30'h0, r}, {30'h0, er});
		cmp_word(d, ed);
	endtask
	// offer one sample; on refusal valid is left standing
	task automatic push(input logic [13:0] v, output bit taken);
		taken = 0;
		@(posedge clk_i);
		sample_i <= v;
		sample_valid_i <= 1'b1;
		for (int n = 0; n < 12 && !taken; n++) begin
			@(posedge clk_i);
			if (sample_ready_o) begin
				sample_valid_i <= 1'b0;
				taken = 1;
			end
		end
	endtask
	task automatic pull(input logic [13:0] exp);
		bit got = 0;
		for (int n = 0; n < 60 && !got; n++) begin
			@(posedge clk_i);
			if (result_valid_o && result_ready_i) begin
				cmp_sample(result_o, exp);
				got = 1;
			end
		end
		if (!got) hang("result");
	endtask
	task automatic one(input logic [13:0] v, input logic [13:0] exp);
		bit t;
		push(v, t);
		if (!t) hang("sample");
		pull(exp);
	endtask
	task automatic pat(input logic [3:0] er, input logic [2:0] e9, input logic [2:0] e10);
		repeat (3) @(posedge clk_i);
		cmp_word({25'h0, rand_o, code9_o}, {25'h0, er, e9});
		cmp_word({29'h0, code10_o}, {29'h0, e10});
	endtask
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic regs_scenario();
		rd(8'hB0, 32'h0, RESP_OKAY);
		rd(8'hB4, 32'h0, RESP_OKAY);
		rd(8'hFC, 32'h0, RESP_OKAY);
		pat(4'h0, 3'h0, 3'h0);
		// status is read only: the write is answered but changes nothing
		wr(8'hFC, 32'hFFFF, RESP_OKAY);
		rd(8'hFC, 32'h0, RESP_OKAY);
		wr(8'h40, 32'h1234, RESP_SLVERR);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(8'hB0, 32'h2BFB, RESP_OKAY);
		rd(8'hB0, 32'h2BFB, RESP_OKAY);
	endtask
	task automatic pattern_scenario();
		wr(8'hB4, 32'h8AC0, RESP_OKAY);
		pat(4'h0, 3'h0, 3'h0);
		wr(8'h10, 32'h0100, RESP_OKAY);
		pat(4'b0001, 3'h5, 3'h3);
		wr(8'hB4, 32'h1000, RESP_OKAY);
		pat(4'b1000, 3'h0, 3'h0);
		wr(8'hB4, 32'h0, RESP_OKAY);
	endtask
	// fill with the far side stalled, then drain in order
	task automatic fifo_scenario();
		bit t = 1;
		int n = 0;
		result_ready_i <= 1'b0;
		while (t && n < 40) begin
			push(14'h100 + 14'(n), t);
			if (t) n++;
		end
		cmp_word(32'(n >= 16), 32'h1);
		// stalled far side: status shows every fifo slot taken
		rd(8'hFC, 32'h10, RESP_OKAY);
		result_ready_i <= 1'b1;
		for (int i = 0; i <= n; i++) begin
			pull(14'h100 + 14'(i));
			if (sample_valid_i && sample_ready_o) sample_valid_i <= 1'b0;
		end
	endtask
	task automatic correction_scenario();
		wr(8'h0C, 32'h0100, RESP_OKAY);
		one(14'd100, 14'd105);
		wr(8'h0C, 32'h1100, RESP_OKAY);
		// code 5 uses factor 0x47CB in Q2.14: 1000 x 18379 / 16384 floors to 1121
		one(14'd995, 14'd1121);
		// gain code zero is unity; offset 0x3FF is minus one step
		wr(8'hB0, 32'h03FF, RESP_OKAY);
		one(14'h0000, 14'h0001);
		wr(8'h0C, 32'h0, RESP_OKAY);
		one(14'd100, 14'd100);
	endtask
	task automatic filter_scenario();
		wr(8'hB4, 32'h0007, RESP_OKAY);
		one(14'd100, 14'd100);
		one(14'd100, 14'd87);
		wr(8'hB4, 32'h0, RESP_OKAY);
		// history is cleared only as a sample passes the bypassed filter
		one(14'd100, 14'd100);
		wr(8'hB4, 32'h0027, RESP_OKAY);
		one(14'd100, 14'd100);
		one(14'd100, 14'd88);
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		rst_n_i = 1'b0;
		sample_i = 14'h0;
		sample_valid_i = 1'b0;
		result_ready_i = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		regs_scenario();
		pattern_scenario();
		fifo_scenario();
		correction_scenario();
		filter_scenario();
		end_of_test();
	end
endmodule
